//--- hw/bsc_ctl.v
// bsc_ctl.v - panel meter front-panel scaling, setpoint and relay logic
// assumes one pclk domain; meas_valid/meas_code come from logic on pclk,
// buttons and jumper headers are asynchronous pins
`timescale 1ns/1ps
`include "bsc_defs.vh"

module bsc_ctl #(
    parameter DEB_CYC   = `BSC_T_DEB_MS * `BSC_CLK_KHZ,
    parameter DLY_CYC   = `BSC_T_DLY_MS * `BSC_CLK_KHZ,
    parameter STEP_CYC  = `BSC_T_STEP_MS * `BSC_CLK_KHZ,
    parameter RST_CYC   = `BSC_T_RST_MS * `BSC_CLK_KHZ,
    parameter FLASH_CYC = `BSC_T_FLASH_MS * `BSC_CLK_KHZ,
    parameter BLINK_CYC = `BSC_T_BLINK_MS * `BSC_CLK_KHZ,
    parameter TW        = 27
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        btn_zero,
    input  wire        btn_span,
    input  wire [3:0]  btn_setpt,
    input  wire [1:0]  jmp_mode,
    input  wire        jmp_czero,
    input  wire [3:0]  jmp_rly_low,
    input  wire        meas_valid,
    input  wire [15:0] meas_code,
    output wire [100:0] seg,
    output wire        led_up,
    output wire        led_down,
    output wire [3:0]  relay,
    output wire        nv_store
);

// ----------------------------------------
// constants
// ----------------------------------------
localparam [TW-1:0] DEB_N   = DEB_CYC - 1;
localparam [TW-1:0] DLY_N   = DLY_CYC - 1;
localparam [TW-1:0] STEP_N  = STEP_CYC - 1;
localparam [TW-1:0] RST_N   = RST_CYC - 1;
localparam [TW-1:0] FLASH_N = FLASH_CYC;
localparam [TW-1:0] BLK_N   = BLINK_CYC - 1;
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_DLY  = 5'h02;
localparam [4:0] ST_ADJ  = 5'h04;
localparam [4:0] ST_BOTH = 5'h08;
localparam [4:0] ST_HOLD = 5'h10;

// ----------------------------------------
// state
// ----------------------------------------
reg  [4:0]        st_q;
reg  [2:0]        sel_q;
reg  [5:0]        dir_q;
reg  [TW-1:0]     tmr_q;
reg  [TW-1:0]     flash_q;
reg  [TW-1:0]     blk_q;
reg               blink_q;
reg  [6:0]        adj_q;
reg  signed [15:0] meas_q;
reg               calc_q;
reg  signed [15:0] in_lo_q;
reg  signed [15:0] in_hi_q;
reg  [6:0]        bar_lo_q;
reg  [6:0]        bar_hi_q;
reg  [1:0]        pt_ok_q;
reg  [6:0]        sp_q [0:3];
reg  [6:0]        pos_q;
reg               under_q;
reg               over_q;
reg  [3:0]        rly_q;
reg  [1:0]        ctrl_q;
reg               nv_q;
reg  [100:0]      seg_q;
reg  [6:0]        jmp_s1_q;
reg  [6:0]        jmp_s2_q;
reg  [2:0]        bsel;
reg  [3:0]        rly_d;
reg  [100:0]      seg_d;
integer           i;
integer           j;
integer           k;
integer           m;
integer           n;

// ----------------------------------------
// pin conditioning
// ----------------------------------------
wire [5:0] btn_raw = {btn_setpt, btn_span, btn_zero};
wire [5:0] btn_db;

genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : g_deb
        bsc_debounce #(
            .CW     (TW),
            .HOLD_N (DEB_N)
        ) u_deb (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .pin     (btn_raw[g]),
            .level   (btn_db[g])
        );
    end
endgenerate

wire [3:0] rly_low = jmp_s2_q[3:0];
wire       czero   = jmp_s2_q[4];
wire [1:0] mode    = jmp_s2_q[6:5];

// ----------------------------------------
// press checks
// ----------------------------------------
wire        both   = btn_db[0] & btn_db[1];
wire        held   = btn_db[sel_q];
wire        adj_on = (st_q == ST_DLY) | (st_q == ST_ADJ);
wire        scal   = adj_on & (sel_q < 3'h2);
wire        sp_adj = adj_on & ~scal;
wire [1:0]  si     = sel_q[1:0] - 2'h2;
wire [1:0]  bi     = bsel[1:0] - 2'h2;
wire signed [16:0] x17  = {meas_q[15], meas_q};
wire signed [16:0] lo17 = {in_lo_q[15], in_lo_q};
wire signed [16:0] hi17 = {in_hi_q[15], in_hi_q};
wire signed [16:0] d_lo = x17 - lo17;
wire signed [16:0] d_hi = x17 - hi17;
wire near_lo = pt_ok_q[0] & (d_lo <= `BSC_IN_P5) & (d_lo >= -`BSC_IN_P5);
wire near_hi = pt_ok_q[1] & (d_hi <= `BSC_IN_P5) & (d_hi >= -`BSC_IN_P5);
wire in_ovr  = (meas_q > `BSC_IN_OVR) | (meas_q < `BSC_IN_UNR);
wire bad_z   = (meas_q < `BSC_IN_ZERO) | (meas_q > `BSC_IN_P95) | near_hi | in_ovr;
wire bad_s   = (meas_q < `BSC_IN_P5) | (meas_q > `BSC_IN_P105) | near_lo | in_ovr;
wire bad     = (bsel == `BSC_BTN_ZERO) ? bad_z : (bsel == `BSC_BTN_SPAN) ? bad_s : 1'b0;
wire sw_rst  = ctrl_q[`BSC_CTRL_SCR];

always @* begin
    bsel = 3'h0;
    for (j = 5; j >= 0; j = j - 1) begin
        if (btn_db[j]) begin
            bsel = j[2:0];
        end
    end
end

// ----------------------------------------
// two point interpolation
// ----------------------------------------
wire signed [7:0]  dbar  = {1'b0, bar_hi_q} - {1'b0, bar_lo_q};
wire signed [16:0] den_s = hi17 - lo17;
wire signed [24:0] num_s = d_lo * dbar;
wire        neg   = num_s[24] ^ den_s[16];
wire [24:0] num_m = num_s[24] ? -num_s : num_s;
wire [16:0] den_m = den_s[16] ? -den_s : den_s;
wire        div_busy;
wire        div_done;
wire [24:0] quo;

bsc_div #(
    .NW (25),
    .DW (17),
    .CW (5)
) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (calc_q & ~div_busy),
    .num     (num_m),
    .den     (den_m),
    .busy    (div_busy),
    .done    (div_done),
    .quo     (quo)
);

wire [25:0] sum    = {19'h0, bar_lo_q} + {1'b0, quo};
wire        up_ovr = ~neg & (sum > {19'h0, `BSC_BAR_MAX});
wire        dn_und = neg & (quo > {18'h0, bar_lo_q});
wire [6:0]  calc_p = dn_und ? `BSC_SEG0 : up_ovr ? `BSC_BAR_MAX :
                     neg ? bar_lo_q - quo[6:0] : sum[6:0];
// while a scaling point is moved the bar shows the point itself
wire [6:0]  new_p  = scal ? adj_q : calc_p;
wire        hyst   = (mode == `BSC_MODE_HYST) & (sp_q[1] > sp_q[0]);

// ----------------------------------------
// relay comparators
// ----------------------------------------
always @* begin
    for (n = 0; n < 4; n = n + 1) begin
        rly_d[n] = rly_low[n] ? (new_p < sp_q[n]) : (new_p >= sp_q[n]);
    end
    if (hyst) begin
        if (rly_low[0]) begin
            rly_d[0] = (new_p < sp_q[0]) ? 1'b1 :
                       (new_p >= sp_q[1]) ? 1'b0 : rly_q[0];
        end else begin
            rly_d[0] = (new_p > sp_q[1]) ? 1'b1 :
                       (new_p <= sp_q[0]) ? 1'b0 : rly_q[0];
        end
    end
end

// ----------------------------------------
// segment image
// ----------------------------------------
wire [6:0] dp = scal ? adj_q : pos_q;

always @* begin : p_seg
    reg [6:0] idx;
    reg [6:0] mk;
    reg       lit;
    idx = 7'h00;
    mk  = 7'h00;
    lit = 1'b0;
    for (i = 0; i <= 100; i = i + 1) begin
        idx = i[6:0];
        if (czero) begin
            lit = (idx >= `BSC_CZ_SEG && idx <= dp) || (idx <= `BSC_CZ_SEG && idx >= dp);
        end else begin
            lit = idx <= dp;
        end
        for (m = 0; m < 4; m = m + 1) begin
            mk = (sp_adj && si == m[1:0]) ? adj_q : sp_q[m];
            if (idx == mk) begin
                lit = dp < mk;
            end
        end
        if (flash_q != {TW{1'b0}} || over_q) begin
            lit = blink_q;
        end else if (under_q) begin
            lit = (idx == `BSC_SEG0) & blink_q;
        end
        seg_d[i] = lit;
    end
end

// ----------------------------------------
// apb slave, zero wait states
// ----------------------------------------
wire acc    = psel & penable;
wire wr_en  = acc & pwrite;
wire map_ok = (paddr == `BSC_A_CTRL) | (paddr == `BSC_A_STAT) | (paddr == `BSC_A_LO) |
              (paddr == `BSC_A_HI) | (paddr == `BSC_A_SETPT);

assign pready   = 1'b1;
assign pslverr  = acc & ~map_ok;
assign led_up   = adj_on & dir_q[sel_q];
assign led_down = adj_on & ~dir_q[sel_q];
assign relay    = rly_q & {4{ctrl_q[`BSC_CTRL_REN]}};
assign nv_store = nv_q;
assign seg      = seg_q;

// ----------------------------------------
// main sequencer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_q     <= ST_IDLE;
        sel_q    <= 3'h0;
        dir_q    <= 6'h00;
        tmr_q    <= {TW{1'b0}};
        flash_q  <= {TW{1'b0}};
        blk_q    <= {TW{1'b0}};
        blink_q  <= 1'b0;
        adj_q    <= 7'h00;
        meas_q   <= 16'sh0000;
        calc_q   <= 1'b0;
        in_lo_q  <= `BSC_IN_ZERO;
        in_hi_q  <= `BSC_IN_FS;
        bar_lo_q <= `BSC_SEG0;
        bar_hi_q <= `BSC_BAR_MAX;
        pt_ok_q  <= 2'h0;
        for (k = 0; k < 4; k = k + 1) begin
            sp_q[k] <= `BSC_SP_RST;
        end
        pos_q    <= 7'h00;
        under_q  <= 1'b0;
        over_q   <= 1'b0;
        rly_q    <= 4'h0;
        ctrl_q   <= `BSC_CTRL_RST;
        nv_q     <= 1'b0;
        seg_q    <= {101{1'b0}};
        jmp_s1_q <= 7'h00;
        jmp_s2_q <= 7'h00;
        prdata   <= 32'h0;
    end else if (clk_en) begin
        jmp_s1_q <= {jmp_mode, jmp_czero, jmp_rly_low};
        jmp_s2_q <= jmp_s1_q;
        seg_q    <= seg_d;
        nv_q     <= 1'b0;
        ctrl_q[`BSC_CTRL_SCR] <= 1'b0;
        tmr_q    <= tmr_q + 1'b1;
        if (flash_q != {TW{1'b0}}) begin
            flash_q <= flash_q - 1'b1;
        end
        if (blk_q == BLK_N) begin
            blk_q   <= {TW{1'b0}};
            blink_q <= ~blink_q;
        end else begin
            blk_q <= blk_q + 1'b1;
        end
        // measurement path
        if (meas_valid) begin
            meas_q <= meas_code;
            calc_q <= 1'b1;
        end else if (!div_busy) begin
            calc_q <= 1'b0;
        end
        if (div_done) begin
            pos_q   <= new_p;
            under_q <= dn_und & ~scal;
            over_q  <= up_ovr & ~scal;
            rly_q   <= rly_d;
        end
        // button sequencer
        case (st_q)
            ST_IDLE: begin
                tmr_q <= {TW{1'b0}};
                if (both) begin
                    st_q <= ST_BOTH;
                end else if (btn_db != 6'h00) begin
                    sel_q       <= bsel;
                    dir_q[bsel] <= ~dir_q[bsel];
                    adj_q       <= (bsel < 3'h2) ? pos_q : sp_q[bi];
                    if (bad) begin
                        flash_q <= FLASH_N;
                        st_q    <= ST_HOLD;
                    end else begin
                        st_q <= ST_DLY;
                    end
                end
            end
            ST_DLY: begin
                if (both) begin
                    st_q  <= ST_BOTH;
                    tmr_q <= {TW{1'b0}};
                end else if (!held) begin
                    st_q <= ST_IDLE;
                end else if (tmr_q == DLY_N) begin
                    st_q  <= ST_ADJ;
                    tmr_q <= {TW{1'b0}};
                end
            end
            ST_ADJ: begin
                if (both) begin
                    st_q  <= ST_BOTH;
                    tmr_q <= {TW{1'b0}};
                end else if (!held) begin
                    st_q <= ST_IDLE;
                    nv_q <= 1'b1;
                    if (sel_q == `BSC_BTN_ZERO) begin
                        in_lo_q    <= meas_q;
                        bar_lo_q   <= adj_q;
                        pt_ok_q[0] <= 1'b1;
                    end else if (sel_q == `BSC_BTN_SPAN) begin
                        in_hi_q    <= meas_q;
                        bar_hi_q   <= adj_q;
                        pt_ok_q[1] <= 1'b1;
                    end else begin
                        sp_q[si] <= adj_q;
                    end
                end else if (tmr_q == STEP_N) begin
                    tmr_q <= {TW{1'b0}};
                    if (dir_q[sel_q] && adj_q != `BSC_BAR_MAX) begin
                        adj_q <= adj_q + 1'b1;
                    end else if (!dir_q[sel_q] && adj_q != `BSC_SEG0) begin
                        adj_q <= adj_q - 1'b1;
                    end
                end
            end
            ST_BOTH: begin
                if (!both) begin
                    st_q <= ST_HOLD;
                end else if (tmr_q == RST_N) begin
                    st_q     <= ST_HOLD;
                    nv_q     <= 1'b1;
                    in_lo_q  <= `BSC_IN_ZERO;
                    in_hi_q  <= `BSC_IN_FS;
                    bar_lo_q <= `BSC_SEG0;
                    bar_hi_q <= `BSC_BAR_MAX;
                    pt_ok_q  <= 2'h0;
                end
            end
            ST_HOLD: begin
                if (btn_db == 6'h00) begin
                    st_q <= ST_IDLE;
                end
            end
            default: begin
                st_q <= ST_IDLE;
            end
        endcase
        // software scale reset acts like the two-button hold
        if (sw_rst) begin
            nv_q     <= 1'b1;
            in_lo_q  <= `BSC_IN_ZERO;
            in_hi_q  <= `BSC_IN_FS;
            bar_lo_q <= `BSC_SEG0;
            bar_hi_q <= `BSC_BAR_MAX;
            pt_ok_q  <= 2'h0;
        end
        // register writes; software restores stored points after power-up
        if (wr_en) begin
            case (paddr)
                `BSC_A_CTRL: ctrl_q <= pwdata[1:0];
                `BSC_A_LO: begin
                    in_lo_q  <= pwdata[15:0];
                    bar_lo_q <= pwdata[22:16];
                end
                `BSC_A_HI: begin
                    in_hi_q  <= pwdata[15:0];
                    bar_hi_q <= pwdata[22:16];
                end
                `BSC_A_SETPT: begin
                    sp_q[0] <= pwdata[6:0];
                    sp_q[1] <= pwdata[14:8];
                    sp_q[2] <= pwdata[22:16];
                    sp_q[3] <= pwdata[30:24];
                end
                default: begin
                end
            endcase
        end
        // read data is fetched in the setup phase
        if (psel && !penable) begin
            case (paddr)
                `BSC_A_CTRL:  prdata <= {30'h0, ctrl_q};
                `BSC_A_STAT:  prdata <= {14'h0, led_down, led_up, relay, hyst,
                                         flash_q != {TW{1'b0}}, over_q, under_q, 1'b0, pos_q};
                `BSC_A_LO:    prdata <= {9'h0, bar_lo_q, in_lo_q};
                `BSC_A_HI:    prdata <= {9'h0, bar_hi_q, in_hi_q};
                `BSC_A_SETPT: prdata <= {1'b0, sp_q[3], 1'b0, sp_q[2],
                                         1'b0, sp_q[1], 1'b0, sp_q[0]};
                default:      prdata <= 32'h0;
            endcase
        end
    end
end

endmodule // bsc_ctl

//--- common/bsc_defs.vh
// bsc_defs.vh - constants of the bargraph scaling and setpoint control
// assumes a 40 MHz pclk and a 16-bit signed conversion result
//
// Notes on behaviour
// - direction led at press, change 0.5 s later
// - each new press reverses the direction
// - each button adjusts only its own value
// - setpoint segment lit below, blank above
// - no jumper: above setpoint; jumper: below
// - mode header picks normal 0 or hysteresis 3
// - mode 3: relay one hysteresis between setpoints
// - low-acting: on below one, off at two
// - high-acting: on above two, off at one
// - low button 0-95%, high button 5-105%
// - adjusted position saturates at zero and full
// - recompute live, store on button release
// - scale from new point and other stored point
// - within 5% of other point: flash, reject
// - both buttons two seconds: default scaling
// - conditioned input beyond limits: flash, reject
// - display header picks standard or centre zero
// - under range flashes first, over flashes all
// - bar and relays follow each measurement
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// ----------------------------------------
// timing, in milliseconds; clock rate in kHz
// ----------------------------------------
`define BSC_CLK_KHZ     40000
`define BSC_T_DLY_MS    500
`define BSC_T_STEP_MS   50
`define BSC_T_RST_MS    2000
`define BSC_T_FLASH_MS  2000
`define BSC_T_BLINK_MS  250
`define BSC_T_DEB_MS    10

// ----------------------------------------
// bar and input codes (2.0 V = full scale)
// ----------------------------------------
`define BSC_BAR_MAX     7'h64
`define BSC_CZ_SEG      7'h32
`define BSC_SEG0        7'h00
`define BSC_IN_ZERO     16'sh0000
`define BSC_IN_FS       16'sh4e20
`define BSC_IN_P5       16'sh03e8
`define BSC_IN_P95      16'sh4a38
`define BSC_IN_P105     16'sh5208
`define BSC_IN_OVR      16'sh5208
`define BSC_IN_UNR      16'shd6fc
`define BSC_MODE_HYST   2'h3
`define BSC_BTN_ZERO    3'h0
`define BSC_BTN_SPAN    3'h1
`define BSC_SP_RST      7'h00

// ----------------------------------------
// register map
// ----------------------------------------
`define BSC_A_CTRL      8'h00
`define BSC_A_STAT      8'h04
`define BSC_A_LO        8'h08
`define BSC_A_HI        8'h0c
`define BSC_A_SETPT     8'h10
`define BSC_CTRL_RST    2'h1
`define BSC_CTRL_REN    0
`define BSC_CTRL_SCR    1

`endif

//--- hw/bsc_debounce.v
// bsc_debounce.v - two-flop synchroniser and debounce filter
// assumes the pin is asynchronous to pclk
`timescale 1ns/1ps

module bsc_debounce #(
    parameter          CW     = 27,
    parameter [CW-1:0] HOLD_N = 1
) (
    input  wire pclk,
    input  wire presetn,
    input  wire clk_en,
    input  wire pin,
    output wire level
);

reg          s1_q;
reg          s2_q;
reg          lvl_q;
reg [CW-1:0] cnt_q;

// level changes only after the pin has stood still for HOLD_N+1 clocks
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_q  <= 1'b0;
        s2_q  <= 1'b0;
        lvl_q <= 1'b0;
        cnt_q <= {CW{1'b0}};
    end else if (clk_en) begin
        s1_q <= pin;
        s2_q <= s1_q;
        if (s2_q == lvl_q) begin
            cnt_q <= {CW{1'b0}};
        end else if (cnt_q == HOLD_N) begin
            lvl_q <= s2_q;
            cnt_q <= {CW{1'b0}};
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
end

assign level = lvl_q;

endmodule // bsc_debounce

//--- hw/bsc_div.v
// bsc_div.v - serial restoring divider, one quotient bit per clock
// assumes start only while busy is low; zero divisor gives all ones only for num below 2^DW
`timescale 1ns/1ps

module bsc_div #(
    parameter NW = 25,
    parameter DW = 17,
    parameter CW = 5
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          clk_en,
    input  wire          start,
    input  wire [NW-1:0] num,
    input  wire [DW-1:0] den,
    output wire          busy,
    output reg           done,
    output wire [NW-1:0] quo
);

reg  [DW-1:0] rem_q;
reg  [NW-1:0] quo_q;
reg  [DW-1:0] den_q;
reg  [CW-1:0] cnt_q;
reg           run_q;
wire [DW:0]   sh   = {rem_q, quo_q[NW-1]};
wire [DW:0]   diff = sh - {1'b0, den_q};
wire          fit  = ~diff[DW];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rem_q <= {DW{1'b0}};
        quo_q <= {NW{1'b0}};
        den_q <= {DW{1'b0}};
        cnt_q <= {CW{1'b0}};
        run_q <= 1'b0;
        done  <= 1'b0;
    end else if (clk_en) begin
        done <= 1'b0;
        if (start && !run_q) begin
            rem_q <= {DW{1'b0}};
            quo_q <= num;
            den_q <= den;
            cnt_q <= NW[CW-1:0];
            run_q <= 1'b1;
        end else if (run_q) begin
            rem_q <= fit ? diff[DW-1:0] : sh[DW-1:0];
            quo_q <= {quo_q[NW-2:0], fit};
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
                run_q <= 1'b0;
                done  <= 1'b1;
            end
        end
    end
end

assign busy = run_q;
assign quo  = quo_q;

endmodule // bsc_div

//--- sim/bsc_conv_model.sv
// bsc_conv_model.sv - conversion source in front of bsc_ctl
// assumes one pclk domain; a result every PER cycles
`timescale 1ns/1ps
module bsc_conv_model #(
    parameter PER = 40
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire  [15:0] code_in,
    output logic        meas_valid,
    output logic [15:0] meas_code
);
    int cnt_q;
    // code is only meaningful with the strobe, so it is inverted between strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            meas_valid <= 1'b0;
            meas_code <= 16'h0000;
        end else begin
            cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
            meas_valid <= (cnt_q == PER - 1);
            meas_code <= (cnt_q == PER - 1) ? code_in : ~code_in;
        end
    end
endmodule // bsc_conv_model

//--- sim/bsc_ctl_asserts.sv
// bsc_ctl_asserts.sv - port checker of bsc_ctl
// assumes binding to bsc_ctl, one pclk domain
`timescale 1ns/1ps
module bsc_ctl_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        meas_valid,
    input wire        led_up,
    input wire        led_down,
    input wire [3:0]  relay,
    input wire        nv_store
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last conversion strobe, saturating
    logic [5:0] age_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_q <= 6'h3f;
        else age_q <= meas_valid ? 6'h00 : (age_q == 6'h3f ? age_q : age_q + 6'h01);
    end
    sequence s_press; $rose(led_up || led_down); endsequence
    sequence s_wr; $past(psel && penable && pwrite); endsequence
    property p_led_one; !(led_up && led_down); endproperty
    property p_led_hold; s_press |=> (led_up || led_down) [*3]; endproperty
    property p_led_flip; $rose(led_down) |-> !$past(led_up); endproperty
    property p_nv_pulse; nv_store |=> !nv_store; endproperty
    property p_rly_upd; $changed(relay) |-> s_wr or (age_q > 6'h14 && age_q < 6'h23); endproperty
    property p_err; pslverr |-> psel && penable; endproperty
    property p_rdy; pready; endproperty
    property p_rd_hold; psel && penable |=> $stable(prdata); endproperty
    a_led_one: assert property (p_led_one) else $error("both leds lit");
    a_led_hold: assert property (p_led_hold) else $error("led dropped early");
    a_led_flip: assert property (p_led_flip) else $error("led swap without release");
    a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
    a_rly_upd: assert property (p_rly_upd) else $error("relay moved between updates");
    a_err: assert property (p_err) else $error("error outside access");
    a_rdy: assert property (p_rdy) else $error("ready low");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved in access");
endmodule // bsc_ctl_asserts

//--- sim/testbench.sv
// testbench.sv - register, relay and button checks of bsc_ctl
// assumes short timer parameters and a conversion every 40 cycles
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serr, meas_valid, led_up, led_down, nv_store;
    logic btn_zero = 1'b0, btn_span = 1'b0, clk_en = 1'b1, jmp_czero = 1'b0;
    logic [3:0] btn_setpt = 4'h0, jmp_rly_low = 4'h0, relay;
    logic [1:0] jmp_mode = 2'h0;
    logic [15:0] code = 16'h0000, meas_code;
    logic [100:0] seg;
    int failures = 0, n_compared = 0;
    always #12.5 pclk = ~pclk;
    bsc_conv_model conv_u (.pclk(pclk), .presetn(presetn), .code_in(code),
        .meas_valid(meas_valid), .meas_code(meas_code));
    // scale reset hold keeps its full length: no scenario holds both buttons
    bsc_ctl #(.DEB_CYC(4), .DLY_CYC(20), .STEP_CYC(5), .FLASH_CYC(30),
        .BLINK_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .btn_zero(btn_zero), .btn_span(btn_span),
        .btn_setpt(btn_setpt), .jmp_mode(jmp_mode), .jmp_czero(jmp_czero),
        .jmp_rly_low(jmp_rly_low), .meas_valid(meas_valid), .meas_code(meas_code),
        .seg(seg), .led_up(led_up), .led_down(led_down), .relay(relay), .nv_store(nv_store));
    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic timeout;
        failures++;
        report_and_stop();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i == 50) timeout();
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bit k of {full bar, store pulse, down led, up led}, sampled mid-cycle
    task automatic wait_cond(input int k);
        int i;
        logic [3:0] v;
        for (i = 0; i < 300; i++) begin
            @(negedge pclk);
            v = {&seg, nv_store, led_down, led_up};
            if (v[k] === 1'b1) break;
        end
        if (i == 300) timeout();
    endtask
    task automatic rly(input logic [1:0] m, input logic [3:0] lo, input logic [15:0] c,
        input logic [3:0] e);
        jmp_mode <= m;
        jmp_rly_low <= lo;
        code <= c;
        repeat (90) @(posedge pclk);
        @(negedge pclk);
        check({28'h0, relay}, {28'h0, e});
        @(posedge pclk);
    endtask
    // hold a setpoint button long enough to reach an end, then read all setpoints
    task automatic hold_sp(input int led, input logic [31:0] b, input logic [31:0] e);
        btn_setpt <= 4'h1;
        wait_cond(led);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, b);
        repeat (700) @(posedge pclk);
        btn_setpt <= 4'h0;
        wait_cond(2);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, e);
        repeat (20) @(posedge pclk);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h00000001);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h00644e20);
        apb(1'b0, 8'h14, 32'h0);
        check({serr, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h10, 32'h32323232);
        rly(2'h0, 4'h5, 16'h3a98, 4'ha);
        rly(2'h0, 4'h5, 16'h1388, 4'h5);
        apb(1'b1, 8'h10, 32'h00003c1e);
        rly(2'h3, 4'h1, 16'h1388, 4'hd);
        rly(2'h3, 4'h1, 16'h2328, 4'hd);
        rly(2'h3, 4'h1, 16'h32c8, 4'he);
        rly(2'h3, 4'h1, 16'h2328, 4'hc);
        rly(2'h3, 4'h0, 16'h32c8, 4'hf);
        rly(2'h3, 4'h0, 16'h2328, 4'hd);
        rly(2'h3, 4'h0, 16'h1388, 4'hc);
        rly(2'h0, 4'h1, 16'h2328, 4'hc);
        hold_sp(0, 32'h00003c1e, 32'h00003c64);
        hold_sp(1, 32'h00003c64, 32'h00003c00);
        jmp_czero <= 1'b1;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        check({24'h0, seg[51:44]}, 32'h0000007e);
        @(posedge pclk);
        jmp_czero <= 1'b0;
        code <= 16'h4c2c;
        repeat (90) @(posedge pclk);
        btn_zero <= 1'b1;
        wait_cond(3);
        check({31'h0, led_up}, 32'h0);
        @(posedge pclk);
        btn_zero <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        report_and_stop();
    end
endmodule // testbench
bind bsc_ctl bsc_ctl_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .led_up(led_up), .led_down(led_down), .relay(relay),
    .nv_store(nv_store));
